/* File: pkg/cpw_map.svh */
// Purpose: offsets, field positions, reset values and timing counts of the PWM block
// Assumes: 10 MHz system clock, 16-bit register port, word addresses
// Notes:   all counts are in counter ticks at the /1 prescale setting
`ifndef CPW_MAP_SVH
`define CPW_MAP_SVH

// register word addresses
`define CPW_A_CTRL     4'h0
`define CPW_A_BUF0     4'h1
`define CPW_A_DEAD     4'h6
`define CPW_A_CNT1     4'h7
`define CPW_A_CNT2     4'h8
`define CPW_A_SYNC     4'h9
`define CPW_A_STATUS   4'ha

// control register fields
`define CPW_C_RUN      0
`define CPW_C_STBY     1
`define CPW_C_ALOW     2
`define CPW_C_DTEN     3
`define CPW_C_CKS_LO   4
`define CPW_C_CKS_HI   6
`define CPW_C_SKIP_LO  8
`define CPW_C_SKIP_HI  11
`define CPW_C_ADCEN    12
`define CPW_CTRL_RST   16'h100c

// timing: clock period, dead time and carrier in ns, counts derived
`define CPW_CLK_NS     100
`define CPW_DEAD_NS    4000
`define CPW_CARRIER_NS 400000
`define CPW_DEAD_CYC   ((`CPW_DEAD_NS + `CPW_CLK_NS - 1) / `CPW_CLK_NS)
`define CPW_HALF_CYC   (`CPW_CARRIER_NS / `CPW_CLK_NS / 2)
`define CPW_UPPER_CYC  (`CPW_HALF_CYC + `CPW_DEAD_CYC)
`define CPW_DUTY_RST   16'h03e8

// interrupt source vector
`define CPW_IRQ_SOURCES 28
`define CPW_IRQ_CREST   0
`define CPW_IRQ_TROUGH  1

`endif

/* File: pkg/cpw_pkg.sv */
// Purpose: shared types of the PWM block
// Assumes: nothing beyond the map header
// Notes:   counter source select covers eight prescale taps
package cpw_pkg;
	typedef logic [15:0] cpw_word_t;
	typedef logic [3:0]  cpw_addr_t;
	typedef enum logic [2:0] {
		CPW_CK_DIV1    = 3'b000,
		CPW_CK_DIV2    = 3'b001,
		CPW_CK_DIV4    = 3'b010,
		CPW_CK_DIV8    = 3'b011,
		CPW_CK_DIV16   = 3'b100,
		CPW_CK_DIV64   = 3'b101,
		CPW_CK_DIV256  = 3'b110,
		CPW_CK_DIV1024 = 3'b111
	} cpw_cksel_t;
endpackage : cpw_pkg

/* File: rtl/cpw_top.sv */
// Purpose: three-phase complementary PWM generator with dead time and A/D trigger
// Assumes: synchronous inputs, one-cycle register strobes, read data one cycle later
// Notes:   buffered compare values move in at every crest and trough
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`include "cpw_map.svh"
`timescale 1ns/100ps

module cpw_top #(
	parameter int NPHASE = 3
) (
	input  wire logic                          sys_clk,
	input  wire logic                          sys_rst,
	input  wire cpw_pkg::cpw_addr_t            regAddr,
	input  wire cpw_pkg::cpw_word_t            regWdata,
	input  wire logic                          regWr,
	input  wire logic                          regRd,
	output cpw_pkg::cpw_word_t                 regRdata,
	output logic                               phaseUPositiveOut,
	output logic                               phaseVPositiveOut,
	output logic                               phaseWPositiveOut,
	output logic                               phaseUInverseOut,
	output logic                               phaseVInverseOut,
	output logic                               phaseWInverseOut,
	output logic                               carrierToggleOut,
	output logic                               adcStartTrigger,
	output logic                               crestIrq,
	output logic                               troughIrq,
	output logic [`CPW_IRQ_SOURCES-1:0]        irqSources
);
	import cpw_pkg::*;
	default clocking cpwCb @(posedge sys_clk); endclocking // every check samples here
	default disable iff (sys_rst);

	// prescale mask for each counter clock source
	function automatic logic [9:0] divMask(input cpw_cksel_t sel);
		unique case (sel)
			CPW_CK_DIV1:    divMask = 10'h000;
			CPW_CK_DIV2:    divMask = 10'h001;
			CPW_CK_DIV4:    divMask = 10'h003;
			CPW_CK_DIV8:    divMask = 10'h007;
			CPW_CK_DIV16:   divMask = 10'h00f;
			CPW_CK_DIV64:   divMask = 10'h03f;
			CPW_CK_DIV256:  divMask = 10'h0ff;
			CPW_CK_DIV1024: divMask = 10'h3ff;
		endcase
	endfunction : divMask

	cpw_word_t      ctrlReg;
	cpw_word_t      deadReg;
	cpw_word_t      bufReg   [5];   // 0 upper, 1 half cycle, 2..4 duty U V W
	cpw_word_t      stageReg [5];
	cpw_word_t      actReg   [5];
	cpw_word_t      cnt1Reg;
	cpw_word_t      cnt2Reg;
	logic           up1Reg;
	logic           up2Reg;
	logic [9:0]     prescReg;
	logic           tickReg;
	logic [3:0]     skipReg;
	logic           toggleReg;
	logic [NPHASE-1:0] posOutReg;
	logic [NPHASE-1:0] invOutReg;
	logic           running;
	logic           crestEvt;
	logic           troughEvt;
	logic           halfEvt;
	logic           issueEvt;

	assign running   = ctrlReg[`CPW_C_RUN] & ~ctrlReg[`CPW_C_STBY];
	assign crestEvt  = tickReg & up1Reg & (cnt1Reg == actReg[0]);
	assign troughEvt = tickReg & ~up2Reg & (cnt2Reg == 16'h0000);
	assign halfEvt   = crestEvt | troughEvt;
	assign issueEvt  = halfEvt & (skipReg >= ctrlReg[`CPW_C_SKIP_HI:`CPW_C_SKIP_LO]);

	////////////////////////////////////////////////////////////////////////////////
	// register port

	// control and dead time registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrlReg <= `CPW_CTRL_RST;
			deadReg <= 16'(`CPW_DEAD_CYC);
		end else if (regWr) begin
			if (regAddr == `CPW_A_CTRL) ctrlReg <= regWdata;
			if (regAddr == `CPW_A_DEAD) deadReg <= regWdata;
		end
	end

	// read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			regRdata <= 16'h0000;
		end else if (regRd) begin
			if (regAddr == `CPW_A_CTRL)
				regRdata <= ctrlReg;
			else if (regAddr >= `CPW_A_BUF0 && regAddr < `CPW_A_DEAD)
				regRdata <= bufReg[3'(regAddr - `CPW_A_BUF0)];
			else if (regAddr == `CPW_A_DEAD)
				regRdata <= deadReg;
			else if (regAddr == `CPW_A_CNT1)
				regRdata <= cnt1Reg;
			else if (regAddr == `CPW_A_CNT2)
				regRdata <= cnt2Reg;
			else if (regAddr == `CPW_A_STATUS)
				regRdata <= {12'h000, toggleReg, up2Reg, up1Reg, running};
			else
				regRdata <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// buffered compare values: buffer, hidden stage, active

	// buffer writes; stage follows on a tick, active takes stage at crest and trough
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 5; i++) begin
				bufReg[i]   <= (i == 0) ? 16'(`CPW_UPPER_CYC) :
				               (i == 1) ? 16'(`CPW_HALF_CYC) : `CPW_DUTY_RST;
				stageReg[i] <= (i == 0) ? 16'(`CPW_UPPER_CYC) :
				               (i == 1) ? 16'(`CPW_HALF_CYC) : `CPW_DUTY_RST;
				actReg[i]   <= (i == 0) ? 16'(`CPW_UPPER_CYC) :
				               (i == 1) ? 16'(`CPW_HALF_CYC) : `CPW_DUTY_RST;
			end
		end else begin
			for (int i = 0; i < 5; i++) begin
				if (regWr && regAddr == 4'(`CPW_A_BUF0 + i))
					bufReg[i] <= regWdata;
				if (!running) begin
					stageReg[i] <= bufReg[i];
					actReg[i]   <= bufReg[i];
				end else if (halfEvt) begin
					actReg[i] <= stageReg[i];
				end else if (tickReg) begin
					stageReg[i] <= bufReg[i];
				end
			end
		end
	end
	property p_crestLoad; (running && crestEvt) |=> actReg[2] == $past(stageReg[2]); endproperty
	a_crestLoad: assert property (p_crestLoad) else $error("crest transfer missing");
	property p_troughLoad; (running && troughEvt) |=> actReg[1] == $past(stageReg[1]); endproperty
	a_troughLoad: assert property (p_troughLoad) else $error("trough transfer missing");

	////////////////////////////////////////////////////////////////////////////////
	// counter clock prescaler

	// one-cycle tick at the selected rate, halted in standby
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prescReg <= 10'h000;
			tickReg  <= 1'b0;
		end else if (running) begin
			prescReg <= prescReg + 10'h001;
			tickReg  <= (prescReg & divMask(cpw_cksel_t'(ctrlReg[`CPW_C_CKS_HI:`CPW_C_CKS_LO])))
			            == divMask(cpw_cksel_t'(ctrlReg[`CPW_C_CKS_HI:`CPW_C_CKS_LO]));
		end else begin
			prescReg <= 10'h000;
			tickReg  <= 1'b0;
		end
	end
	property p_standby; ctrlReg[`CPW_C_STBY] |=> !tickReg ##1 !crestIrq && !troughIrq; endproperty
	a_standby: assert property (p_standby) else $error("timer ran in standby");

	////////////////////////////////////////////////////////////////////////////////
	// linked up/down counters

	// first counter: dead time up to upper limit and back
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt1Reg <= 16'(`CPW_DEAD_CYC);
			up1Reg  <= 1'b1;
		end else if (regWr && (regAddr == `CPW_A_CNT1 || regAddr == `CPW_A_SYNC)) begin
			cnt1Reg <= regWdata;
		end else if (tickReg) begin
			if (up1Reg) begin
				if (cnt1Reg == actReg[0]) begin
					up1Reg  <= 1'b0;
					cnt1Reg <= cnt1Reg - 16'h0001;
				end else begin
					cnt1Reg <= cnt1Reg + 16'h0001;
				end
			end else if (cnt1Reg == deadReg) begin
				up1Reg  <= 1'b1;
				cnt1Reg <= cnt1Reg + 16'h0001;
			end else begin
				cnt1Reg <= cnt1Reg - 16'h0001;
			end
		end
	end
	property p_turnDown; (crestEvt && !regWr) |=>
		!up1Reg && cnt1Reg == $past(cnt1Reg) - 16'h0001; endproperty
	a_turnDown: assert property (p_turnDown) else $error("first counter did not turn");

	// second counter: zero up to half carrier and back
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt2Reg <= 16'h0000;
			up2Reg  <= 1'b1;
		end else if (regWr && (regAddr == `CPW_A_CNT2 || regAddr == `CPW_A_SYNC)) begin
			cnt2Reg <= regWdata;
		end else if (tickReg) begin
			if (up2Reg) begin
				if (cnt2Reg == actReg[1]) begin
					up2Reg  <= 1'b0;
					cnt2Reg <= cnt2Reg - 16'h0001;
				end else begin
					cnt2Reg <= cnt2Reg + 16'h0001;
				end
			end else if (cnt2Reg == 16'h0000) begin
				up2Reg  <= 1'b1;
				cnt2Reg <= 16'h0001;
			end else begin
				cnt2Reg <= cnt2Reg - 16'h0001;
			end
		end
	end
	property p_turnUp; (troughEvt && !regWr) |=> up2Reg && cnt2Reg == 16'h0001; endproperty
	a_turnUp: assert property (p_turnUp) else $error("second counter did not turn");
	property p_syncLoad; (regWr && regAddr == `CPW_A_SYNC) |=>
		cnt1Reg == $past(regWdata) && cnt2Reg == $past(regWdata); endproperty
	a_syncLoad: assert property (p_syncLoad) else $error("sync load failed");

	////////////////////////////////////////////////////////////////////////////////
	// events: toggle pin, interrupts, A/D trigger

	// toggle pin flips at every crest and trough
	always_ff @(posedge sys_clk) begin
		if (sys_rst) toggleReg <= 1'b0;
		else if (halfEvt) toggleReg <= ~toggleReg;
	end
	property p_toggle; halfEvt |=> carrierToggleOut != $past(carrierToggleOut); endproperty
	a_toggle: assert property (p_toggle) else $error("toggle missed half period");

	// skip counter and event pulses
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			skipReg         <= 4'h0;
			crestIrq        <= 1'b0;
			troughIrq       <= 1'b0;
			adcStartTrigger <= 1'b0;
			irqSources      <= '0;
		end else begin
			if (halfEvt)
				skipReg <= issueEvt ? 4'h0 : skipReg + 4'h1;
			crestIrq        <= issueEvt & crestEvt;
			troughIrq       <= issueEvt & troughEvt;
			adcStartTrigger <= issueEvt & troughEvt & ctrlReg[`CPW_C_ADCEN];
			irqSources      <= '0;
			irqSources[`CPW_IRQ_CREST]  <= issueEvt & crestEvt;
			irqSources[`CPW_IRQ_TROUGH] <= issueEvt & troughEvt;
		end
	end
	property p_irqOnce; (issueEvt && crestEvt) |=>
		crestIrq && irqSources[`CPW_IRQ_CREST] ##1 !crestIrq; endproperty
	a_irqOnce: assert property (p_irqOnce) else $error("crest interrupt wrong");

	////////////////////////////////////////////////////////////////////////////////
	// phase outputs with dead time

	genvar p;
	generate
		for (p = 0; p < NPHASE; p++) begin : g_phase
			cpw_word_t dtCntReg;
			logic      reqReg;
			logic      settled;
			logic      posOn;
			logic      invOn;

			assign settled = ~ctrlReg[`CPW_C_DTEN] | (dtCntReg >= deadReg);
			assign posOn   = running & reqReg & settled;
			assign invOn   = running & ~reqReg & settled;

			// request follows the compare, dead count restarts on change
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					reqReg   <= 1'b0;
					dtCntReg <= 16'h0000;
				end else if (tickReg && (cnt2Reg < actReg[p + 2]) != reqReg) begin
					reqReg   <= cnt2Reg < actReg[p + 2];
					dtCntReg <= 16'h0000;
				end else if (tickReg && dtCntReg != 16'hffff) begin
					dtCntReg <= dtCntReg + 16'h0001;
				end
			end

			// pins, inactive level while stopped
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					posOutReg[p] <= 1'b1;
					invOutReg[p] <= 1'b1;
				end else begin
					posOutReg[p] <= posOn ^ ctrlReg[`CPW_C_ALOW];
					invOutReg[p] <= invOn ^ ctrlReg[`CPW_C_ALOW];
				end
			end

			property p_noOverlap;
				(ctrlReg[`CPW_C_DTEN] && $stable(ctrlReg[`CPW_C_ALOW])) |-> // level change skipped
					!(posOutReg[p] == ~ctrlReg[`CPW_C_ALOW] && invOutReg[p] == ~ctrlReg[`CPW_C_ALOW]);
			endproperty
			a_noOverlap: assert property (p_noOverlap) else $error("paired outputs overlap");
		end
	endgenerate

	assign phaseUPositiveOut = posOutReg[0];
	assign phaseVPositiveOut = posOutReg[1];
	assign phaseWPositiveOut = posOutReg[2];
	assign phaseUInverseOut  = invOutReg[0];
	assign phaseVInverseOut  = invOutReg[1];
	assign phaseWInverseOut  = invOutReg[2];
	assign carrierToggleOut  = toggleReg;

endmodule : cpw_top

/* File: dv/cpw_partner.sv */
// Purpose: gate driver and A/D converter stand-in at the PWM pins
// Assumes: pins are low-active whenever widths and gaps are read
// Notes:   reports leg shorts, trigger count, on-times and dead gaps
`timescale 1ns/100ps

module cpw_partner (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic [2:0] posPin,
	input  wire logic [2:0] invPin,
	input  wire logic       adcStartTrigger,
	output int              shortCount,
	output int              adcCount,
	output int              lowWidth [3],
	output int              deadGap [3]
);
	int widthCnt [3];
	int gapCnt [3];

	////////////////////////////////////////////////////////////////////////
	// a bridge leg shorts if both of its switches conduct in one cycle
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			shortCount <= 0;
			adcCount <= 0;
		end else begin
			if ((~posPin & ~invPin) != 3'h0) shortCount <= shortCount + 1;
			if (adcStartTrigger === 1'b1) adcCount <= adcCount + 1;
		end
	end

	// on-time of each upper switch and off gap before its lower switch
	always @(posedge sys_clk) begin
		for (int p = 0; p < 3; p++) begin
			widthCnt[p] <= posPin[p] ? 0 : widthCnt[p] + 1;
			if (posPin[p] === 1'b1 && widthCnt[p] != 0) lowWidth[p] <= widthCnt[p];
			gapCnt[p] <= (posPin[p] && invPin[p]) ? gapCnt[p] + 1 : 0;
			if (invPin[p] === 1'b0 && gapCnt[p] != 0) deadGap[p] <= gapCnt[p];
		end
	end
endmodule : cpw_partner

/* File: dv/tb_complementary_three_phase_pwm.sv */
// Purpose: self-checking bench of the complementary PWM block
// Assumes: 10 MHz clock, register port with read data one cycle later
// Notes:   random duties from a fixed seed, partner watches the pins
`include "cpw_map.svh"
`timescale 1ns/100ps

module tb_complementary_three_phase_pwm;
	import cpw_pkg::*;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	cpw_addr_t   regAddr = 4'h0;
	cpw_word_t   regWdata = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	cpw_word_t   regRdata;
	logic [2:0]  pos;
	logic [2:0]  inv;
	logic        tog, adc, crest, trough;
	logic [27:0] irqSrc;
	int          mismatches = 0;
	int          num_checks = 0;
	int          shortCount, adcCount;
	int          lowWidth [3];
	int          deadGap [3];
	int          crestN, troughN, togN, adcN, bad, crestGap, lastCrest;
	cpw_word_t   rd;
	cpw_word_t   duty [3];
	cpw_word_t   expRst [12];
	logic        prevTog;

	always #50 sys_clk = ~sys_clk;

	cpw_top u_cpw_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.phaseUPositiveOut(pos[0]), .phaseVPositiveOut(pos[1]), .phaseWPositiveOut(pos[2]),
		.phaseUInverseOut(inv[0]), .phaseVInverseOut(inv[1]), .phaseWInverseOut(inv[2]),
		.carrierToggleOut(tog), .adcStartTrigger(adc), .crestIrq(crest), .troughIrq(trough),
		.irqSources(irqSrc));

	cpw_partner u_cpw_partner (.sys_clk(sys_clk), .sys_rst(sys_rst), .posPin(pos),
		.invPin(inv), .adcStartTrigger(adc), .shortCount(shortCount), .adcCount(adcCount),
		.lowWidth(lowWidth), .deadGap(deadGap));

	////////////////////////////////////////////////////////////////////////
	// register port cycles and comparison
	task automatic wr(input cpw_addr_t a, input cpw_word_t d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask : wr

	task automatic rdreg(input cpw_addr_t a);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 rd = regRdata;
	endtask : rdreg

	task automatic chk(input cpw_word_t got, input cpw_word_t exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// expected on-time of an upper switch: ticks below duty around zero, less dead time
	function automatic int expWidth(input cpw_word_t d);
		return 2 * int'(d) - 1 - `CPW_DEAD_CYC;
	endfunction : expWidth

	task automatic chkWidths();
		for (int p = 0; p < 3; p++) begin
			chk(16'(lowWidth[p]), 16'(expWidth(duty[p])));
			chk(16'(deadGap[p]), 16'(`CPW_DEAD_CYC));
		end
	endtask : chkWidths

	// count pulses and toggle flips over n cycles
	task automatic watch(input int n);
		crestN = 0;
		troughN = 0;
		togN = 0;
		adcN = 0;
		bad = 0;
		lastCrest = -1;
		crestGap = 0;
		prevTog = tog;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			#1;
			if (crest && lastCrest >= 0) crestGap = i - lastCrest;
			if (crest) lastCrest = i;
			crestN += crest;
			troughN += trough;
			adcN += adc;
			togN += (tog !== prevTog);
			prevTog = tog;
			if (irqSrc !== {26'h0, trough, crest}) bad++;
		end
	endtask : watch

	task automatic conclude();
		if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		#(100 * 60000);
		mismatches++;
		conclude();
	end

	// main sequence
	initial begin
		void'($urandom(22936));
		expRst = '{`CPW_CTRL_RST, 16'(`CPW_UPPER_CYC), 16'(`CPW_HALF_CYC), `CPW_DUTY_RST,
			`CPW_DUTY_RST, `CPW_DUTY_RST, 16'(`CPW_DEAD_CYC), 16'(`CPW_DEAD_CYC), 16'h0000,
			16'h0000, 16'h0006, 16'h0000};
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 12; a++) begin
			rdreg(cpw_addr_t'(a));
			chk(rd, expRst[a]);
		end
		for (int k = 0; k < 8; k++) begin
			wr(`CPW_A_CTRL, 16'h100c | 16'(k << `CPW_C_CKS_LO));
			rdreg(`CPW_A_CTRL);
			chk(rd, 16'h100c | 16'(k << `CPW_C_CKS_LO));
		end
		wr(`CPW_A_CTRL, `CPW_CTRL_RST);
		duty[0] = 16'($urandom_range(1800, 200));
		wr(`CPW_A_SYNC, duty[0]);
		rdreg(`CPW_A_CNT1);
		chk(rd, duty[0]);
		rdreg(`CPW_A_CNT2);
		chk(rd, duty[0]);
		wr(`CPW_A_CNT1, 16'(`CPW_DEAD_CYC));
		wr(`CPW_A_CNT2, 16'h0000);
		for (int p = 0; p < 3; p++) begin
			duty[p] = 16'($urandom_range(1800, 200));
			wr(cpw_addr_t'(3 + p), duty[p]);
			rdreg(cpw_addr_t'(3 + p));
			chk(rd, duty[p]);
		end
		wr(`CPW_A_CTRL, 16'h100d);
		rdreg(`CPW_A_STATUS);
		chk(rd & 16'h0001, 16'h0001);
		watch(9000);
		chk(16'(crestGap), 16'(2 * `CPW_HALF_CYC));
		chk(16'(togN), 16'(crestN + troughN));
		chk(16'(adcN), 16'(troughN));
		chk(16'(bad), 16'h0000);
		chkWidths();
		for (int i = 0; i < 5000 && crest !== 1'b1; i++) @(posedge sys_clk);
		duty[0] = duty[0] + 16'h0064;
		wr(4'h3, duty[0]);
		watch(8100);
		chkWidths();
		wr(`CPW_A_CTRL, 16'h110d);
		watch(8000);
		chk(16'(crestN + troughN), 16'h0002);
		wr(`CPW_A_CTRL, 16'h101d);
		watch(17000);
		chk(16'(crestGap), 16'(4 * `CPW_HALF_CYC));
		wr(`CPW_A_CTRL, 16'h100f);
		watch(3000);
		chk(16'(crestN + troughN), 16'h0000);
		chk(16'({pos, inv}), 16'h003f);
		chk(16'(shortCount), 16'h0000);
		wr(`CPW_A_CTRL, 16'h1008);
		watch(4);
		chk(16'({pos, inv}), 16'h0000);
		chk(16'(adcCount > 0), 16'h0001);
		conclude();
	end
endmodule : tb_complementary_three_phase_pwm
